//--- padc_pkg.sv
package padc_pkg;
  localparam int WORD_W = 10;
  localparam int STAGES = 9;
  localparam int STAGE_W = 2;
  localparam int FIFO_DEPTH = 8;
  // latency in half-cycles of the convert clock (6.5 cycles)
  localparam int LAT_HALF = 13;
  localparam int CODE_W = 19;
  localparam logic [CODE_W-1:0] CODE_MAX = 19'h003ff;
  localparam logic [WORD_W-1:0] TOP_BIT_MASK = 10'h200;

  typedef struct packed {
    logic [STAGES-1:0][STAGE_W-1:0] stage_bits;
  } padc_stage_set_s;

  typedef struct packed {
    logic [WORD_W-1:0] word;
  } padc_sample_s;
endpackage

//--- padc_fifo.sv
`timescale 1ns/1ps
module padc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready_out = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out = mem_reg[rd_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb
  begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push)
      mem_reg[wr_reg] <= in_data_in;
  end
endmodule

//--- padc_output_logic.sv
`timescale 1ns/1ps
// Summary of operation
// R1: valid output word appears 6.5 convert-clock cycles after its starting edge.
// R2: nine pipeline stages, each resolving a 2-bit result.
// R3: stages resolve on a sub-clock at twice the convert clock rate.
// R4: each stage result is delayed so a sample's results align.
// R5: correction sums aligned results with redundancy; no missing codes.
// R6: top-bit invert low gives straight offset binary, full scale all ones.
// R7: top-bit invert high inverts only the top bit, two's complement.
// R8: float control high releases all data outputs; low drives them.
// R9: controller holds float control static, as a test feature only.
// R10: interstage conversions advance on both convert clock edges.
// R11: convert clock should be 50 percent duty with low jitter.
// R12: two non-overlapping phases: sample in first, hold in second.
// R13: top bit on first data output, bottom bit on tenth.
// R14: one new sample word per convert-clock cycle continuously.
module padc_output_logic (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // convert clock, sampled as ordinary input
  input wire logic convert_clock_in,
  // per-stage 2-bit quantizer decisions from the analog side
  input wire logic [padc_pkg::STAGES-1:0][padc_pkg::STAGE_W-1:0] stage_decision_in,
  // control pins
  input wire logic top_bit_invert_select_in,
  input wire logic output_float_in,
  // sample output: index 9 is sample_bit_top, index 0 sample_bit_bottom
  output logic [padc_pkg::WORD_W-1:0] sample_word_out,
  output logic [padc_pkg::WORD_W-1:0] sample_oe_n_out,
  output logic sample_valid_out,
  input wire logic sample_ready_in,
  // sample and hold phases
  output logic phase_sample_out,
  output logic phase_hold_out
);
  localparam int S = padc_pkg::STAGES;
  localparam int W = padc_pkg::STAGE_W;
  localparam int L = padc_pkg::LAT_HALF;

  logic clk_prev_reg, clk_prev_next;
  logic sub_tick, rise;
  logic [S-1:0][W-1:0] delay_reg [S];
  logic [S-1:0][W-1:0] delay_next [S];
  logic [L-1:0] lat_reg, lat_next;
  logic [padc_pkg::WORD_W-1:0] word_reg, word_next;
  logic [padc_pkg::WORD_W-1:0] corrected;
  logic fifo_in_ready, fifo_valid;
  logic [padc_pkg::WORD_W-1:0] fifo_data;
  logic ph1_reg, ph1_next, ph2_reg, ph2_next;

  // correction: weighted sum, each stage overlapping the next by one bit
  function automatic logic [padc_pkg::WORD_W-1:0] correct(
    input logic [S-1:0][W-1:0] st);
    logic [padc_pkg::CODE_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < S; i++)
      acc = acc + (padc_pkg::CODE_W'(st[i]) << (S - 1 - i));
    if (acc > padc_pkg::CODE_MAX)
      acc = padc_pkg::CODE_MAX;
    return acc[padc_pkg::WORD_W-1:0];
  endfunction

  // R10 R3 both edges: sub-clock tick at twice convert rate
  assign sub_tick = convert_clock_in ^ clk_prev_reg;
  assign rise = convert_clock_in & ~clk_prev_reg;

  always_comb
  begin
    clk_prev_next = convert_clock_in;
    // R12 non-overlapping phases: a dead cycle on every edge
    ph1_next = convert_clock_in & ~sub_tick;
    ph2_next = ~convert_clock_in & ~sub_tick;
  end

  // R4 delay chains: stage i waits S-1-i half-cycles after capture
  always_comb
  begin
    for (int i = 0; i < S; i++)
      delay_next[i] = delay_reg[i];
    if (sub_tick)
    begin
      for (int i = 0; i < S; i++)
      begin
        // R2 stage captures its 2-bit decision into slot i
        // first chain has no predecessor, so it never reads below index zero
        if (i == 0)
          delay_next[i] = '0;
        else
          delay_next[i] = delay_reg[i-1];
        delay_next[i][i] = stage_decision_in[i];
      end
    end
  end

  // R5 correction of aligned results
  assign corrected = correct(delay_reg[S-1]);

  // R1 latency tracker: launch on rising edge, output 13 half-cycles later
  always_comb
  begin
    lat_next = lat_reg;
    word_next = word_reg;
    if (sub_tick)
    begin
      lat_next = {lat_reg[L-2:0], rise};
      // R7 two's complement by top-bit inversion; R6 straight otherwise
      if (lat_reg[L-2])
        word_next = top_bit_invert_select_in ? (corrected ^ padc_pkg::TOP_BIT_MASK)
                                             : corrected;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      clk_prev_reg <= 1'b0;
      lat_reg <= '0;
      word_reg <= '0;
      ph1_reg <= 1'b0;
      ph2_reg <= 1'b0;
      for (int i = 0; i < S; i++)
        delay_reg[i] <= '0;
    end
    else
    begin
      clk_prev_reg <= clk_prev_next;
      lat_reg <= lat_next;
      word_reg <= word_next;
      ph1_reg <= ph1_next;
      ph2_reg <= ph2_next;
      for (int i = 0; i < S; i++)
        delay_reg[i] <= delay_next[i];
    end
  end

  // R14 one word per convert cycle enters the buffer
  padc_fifo #(.WIDTH(padc_pkg::WORD_W), .DEPTH(padc_pkg::FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(sub_tick && lat_reg[L-1]),
    .in_ready_out(fifo_in_ready),
    .in_data_in(word_reg),
    .out_valid_out(fifo_valid),
    .out_ready_in(sample_ready_in),
    .out_data_out(fifo_data)
  );

  // R13 bit order: word[9] is first pin; R8 float releases all pins
  assign sample_word_out = fifo_data;
  assign sample_oe_n_out = {padc_pkg::WORD_W{output_float_in}};
  assign sample_valid_out = fifo_valid && !output_float_in;
  assign phase_sample_out = ph1_reg;
  assign phase_hold_out = ph2_reg;

  a_phase_excl: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !(ph1_reg && ph2_reg)) else $error("phases overlap"); // R12
  a_float_release: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    output_float_in |-> &sample_oe_n_out) else $error("outputs driven in float"); // R8
  a_float_drive: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !output_float_in |-> sample_oe_n_out == '0) else $error("outputs not driven"); // R8
  a_top_invert: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    sub_tick && lat_reg[L-2] && top_bit_invert_select_in |=>
    word_reg == (($past(corrected)) ^ padc_pkg::TOP_BIT_MASK))
    else $error("top bit not inverted"); // R7
  a_straight_code: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    sub_tick && lat_reg[L-2] && !top_bit_invert_select_in |=> word_reg == $past(corrected))
    else $error("straight code wrong"); // R6
  a_fifo_ovf: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    sub_tick && lat_reg[L-1] |-> fifo_in_ready || !sample_ready_in)
    else $error("sample lost while drained"); // R14
  c_invert: cover property (@(posedge clock_in) top_bit_invert_select_in && fifo_valid);
  c_float: cover property (@(posedge clock_in) output_float_in);
  c_word: cover property (@(posedge clock_in) sample_valid_out && sample_ready_in);
endmodule

//--- padc_capture.sv
`timescale 1ns/1ps
module padc_capture (
  // clock and stall control
  input wire logic clock_in,
  input wire logic stall_in,
  // sample side
  input wire logic sample_valid_in,
  input wire logic [padc_pkg::WORD_W-1:0] sample_word_in,
  output logic sample_ready_out,
  output logic [padc_pkg::WORD_W-1:0] last_word_out,
  output int pops_out = 0
);
  assign sample_ready_out = !stall_in;
  // latch a word only on a real handshake
  always @(posedge clock_in)
  begin
    if (sample_valid_in && sample_ready_out)
    begin
      last_word_out <= sample_word_in;
      pops_out <= pops_out + 1;
    end
  end
endmodule

//--- tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb;
  logic clock_in = 0, reset_n_in = 0, conv = 0, cv_en = 0, inv = 0, flt = 0, stall = 0;
  logic [padc_pkg::STAGES-1:0][padc_pkg::STAGE_W-1:0] dec = '0;
  logic [padc_pkg::WORD_W-1:0] oe_n, word, last;
  logic valid, ready, ph_s, ph_h;
  int pops, miscompares = 0, num_checks = 0, cc = 0, p0, n;
  padc_output_logic DUT (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .convert_clock_in(conv), .stage_decision_in(dec), .top_bit_invert_select_in(inv),
    .output_float_in(flt), .sample_word_out(word), .sample_oe_n_out(oe_n),
    .sample_valid_out(valid), .sample_ready_in(ready), .phase_sample_out(ph_s),
    .phase_hold_out(ph_h));
  padc_capture CAP (.clock_in(clock_in), .stall_in(stall), .sample_valid_in(valid),
    .sample_word_in(word), .sample_ready_out(ready), .last_word_out(last), .pops_out(pops));
  always #5 clock_in = ~clock_in;
  // even duty, 20 system clocks per convert cycle
  always @(negedge clock_in)
  begin
    cc <= (!cv_en || cc == 9) ? 0 : cc + 1;
    conv <= !cv_en ? 1'b0 : (cc == 9 ? ~conv : conv);
  end
  function automatic logic [9:0] exp_word(input logic [17:0] d, input logic i);
    logic [18:0] s;
    s = '0;
    for (int k = 0; k < 9; k++) s += 19'(d[2*k +: 2]) << (8 - k);
    if (s > padc_pkg::CODE_MAX) s = padc_pkg::CODE_MAX;
    return s[9:0] ^ (i ? padc_pkg::TOP_BIT_MASK : 10'h000);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_latency();
    @(negedge clock_in) cv_en = 0;
    reset_n_in = 0;
    repeat (4) @(negedge clock_in);
    reset_n_in = 1;
    cv_en = 1;
    n = 0;
    @(posedge conv);
    // sampled off the launching edge so valid is settled
    while (!valid && n < 300)
    begin
      @(negedge clock_in);
      n++;
    end
    `CHK("latency", 1'b1, n >= 130 && n <= 134)
    $display("t_latency done");
  endtask
  task automatic t_codes();
    logic [17:0] pat [5] = '{18'h00000, 18'h3ffff, 18'h15555, 18'h00001, 18'h10000};
    // float held static while codes are taken
    for (int j = 0; j < 10; j++)
    begin
      @(negedge clock_in) dec = pat[j/2];
      inv = j[0];
      repeat (600) @(posedge clock_in);
      `CHK("code", exp_word(pat[j/2], j[0]), last)
    end
    inv = 0;
    $display("t_codes done");
  endtask
  task automatic t_float();
    @(negedge clock_in) flt = 1;
    repeat (40) @(negedge clock_in);
    `CHK("oe_n float", 10'h3ff, oe_n)
    `CHK("valid float", 1'b0, valid)
    flt = 0;
    @(negedge clock_in);
    `CHK("oe_n drive", 10'h000, oe_n)
    repeat (100) @(negedge clock_in);
    $display("t_float done");
  endtask
  task automatic t_rate();
    @(posedge conv);
    p0 = pops;
    repeat (3) @(negedge clock_in);
    `CHK("phase sample", 1'b1, ph_s)
    `CHK("phase hold", 1'b0, ph_h)
    repeat (10) @(negedge clock_in);
    `CHK("phase sample low", 1'b0, ph_s)
    `CHK("phase hold high", 1'b1, ph_h)
    repeat (187) @(posedge clock_in);
    `CHK("rate", 10, pops - p0)
    $display("t_rate done");
  endtask
  task automatic t_fifo();
    @(negedge clock_in) stall = 1;
    repeat (400) @(negedge clock_in);
    `CHK("full valid", 1'b1, valid)
    p0 = pops;
    stall = 0;
    repeat (8) @(negedge clock_in);
    // eight held words pop back to back, whatever the push phase
    `CHK("drain", 8, pops - p0)
    $display("t_fifo done");
  endtask
  initial
  begin
    #300000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    t_latency();
    t_codes();
    t_float();
    t_rate();
    t_fifo();
    end_of_test();
  end
endmodule
